/* common/alc_pkg.sv */
// Purpose: Shared constants and carrier types for the ancillary channel result and limit block.
// Assumes: 5-bit register addresses and 12-bit converter codes.
// Notes:   Limit pairs are laid out high then low for each checked channel.
package alc_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 12;
	localparam int CHAN_W = 4;
	localparam int NUM_CHECKED = 4;
	localparam int NUM_RESULTS = 7;
	localparam int NUM_LIMITS = 8;

	// Channel select codes.
	localparam logic [3:0] CH_SPARE_A = 4'h3;
	localparam logic [3:0] CH_SPARE_B = 4'h4;
	localparam logic [3:0] CH_SPARE_C = 4'h5;
	localparam logic [3:0] CH_BATT_A = 4'h6;
	localparam logic [3:0] CH_BATT_B = 4'h7;
	localparam logic [3:0] CH_DIODE_LOW = 4'h8;
	localparam logic [3:0] CH_DIODE_HIGH = 4'h9;

	// Register offsets.
	localparam logic [4:0] ALERT_STATUS_ENABLE_ADDR = 5'h03;
	localparam logic [4:0] LIMIT_FIRST_ADDR = 5'h04;
	localparam logic [4:0] LIMIT_LAST_ADDR = 5'h0b;
	localparam logic [4:0] AUX_INPUT_A_RESULT_ADDR = 5'h13;
	localparam logic [4:0] AUX_INPUT_B_RESULT_ADDR = 5'h14;
	localparam logic [4:0] AUX_INPUT_C_RESULT_ADDR = 5'h15;
	localparam logic [4:0] BATTERY_A_RESULT_ADDR = 5'h16;
	localparam logic [4:0] BATTERY_B_RESULT_ADDR = 5'h17;
	localparam logic [4:0] DIODE_LOW_BIAS_RESULT_ADDR = 5'h18;
	localparam logic [4:0] DIODE_HIGH_BIAS_RESULT_ADDR = 5'h19;

	// Alert status/enable field positions.
	localparam int ALERT_STATUS_LSB = 0;
	localparam int ALERT_ENABLE_LSB = 4;

	// Reset values.
	localparam logic [11:0] RESULT_RST = 12'h000;
	localparam logic [11:0] HIGH_LIMIT_RST = 12'hfff;
	localparam logic [11:0] LOW_LIMIT_RST = 12'h000;
	localparam logic [3:0] ALERT_STATUS_RST = 4'h0;
	localparam logic [3:0] ALERT_ENABLE_RST = 4'h0;

	typedef struct packed {
		logic              valid;
		logic [CHAN_W-1:0] channel;
		logic [DATA_W-1:0] data;
	} alc_conv_t;

	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} alc_wr_t;

endpackage : alc_pkg

/* rtl/alc_aux_limit.sv */
// Purpose: Routes ancillary conversion codes to result registers and checks limits.
// Assumes: Converter, sampler and register port all run on clk; one result per conv.valid.
// Notes:   Reads answer one cycle after reg_rd_en; unmapped addresses read zero.
//
// What this block does
// - Single diode measurement uses the low-bias channel code only.
// - Differential diode sensing uses low-bias then high-bias consecutive channel codes.
// - Low and high bias diode results go to their two result registers.
// - Only raw diode codes are stored; no temperature arithmetic exists.
// - Temperature limit check uses the raw low-bias diode result.
// - Battery halving divider is enabled only while that battery is sampled.
// - First battery channel code stores into its result register.
// - Second battery channel code stores into its result register.
// - Spare analog inputs a, b, c take consecutive channel codes.
// - Spare analog results land in three consecutive result registers, same order.
// - Spare analog pins may be reassigned as general purpose digital pins.
// - Four channels are limit checked and may raise the alarm output.
// - Limits sit in a contiguous writable register block.
// - Each completed checked conversion is compared with both its limits.
// - Out of limit result sets that channel's alert status bit.
`timescale 1ns/1ps

module alc_aux_limit
	import alc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire alc_conv_t         conv,
	input  wire logic              sample_active,
	input  wire logic [CHAN_W-1:0] sample_channel,
	input  wire logic [2:0]        spare_gpio_mode,
	input  wire alc_wr_t           reg_wr,
	input  wire logic              reg_rd_en,
	input  wire logic [ADDR_W-1:0] reg_rd_addr,
	output logic      [DATA_W-1:0] reg_rd_data,
	output logic                   reg_rd_valid,
	output logic                   battery_a_div_en,
	output logic                   battery_b_div_en,
	output logic                   alarm
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	logic [DATA_W-1:0] result_reg [NUM_RESULTS];
	logic [DATA_W-1:0] result_next [NUM_RESULTS];
	logic [DATA_W-1:0] limit_reg [NUM_LIMITS];
	logic [DATA_W-1:0] limit_next [NUM_LIMITS];
	logic [3:0]        status_reg;
	logic [3:0]        status_next;
	logic [3:0]        enable_reg;
	logic [3:0]        enable_next;
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_data_next;
	logic              rd_valid_reg;
	logic              rd_valid_next;
	logic              div_a_reg;
	logic              div_a_next;
	logic              div_b_reg;
	logic              div_b_next;
	logic              alarm_reg;
	logic              alarm_next;

	////////////////////////////////////////////////////////////////////////////////
	// Decode of the converted channel.

	logic       res_hit;
	logic [2:0] res_idx;
	logic       chk_hit;
	logic [1:0] chk_idx;
	logic       out_of_limit;
	logic [3:0] set_mask;

	always_comb begin
		res_idx = 3'(conv.channel - CH_SPARE_A);
		// Pins in digital mode hold no analog value, so their codes are dropped.
		res_hit = conv.valid && conv.channel >= CH_SPARE_A
			&& conv.channel <= CH_DIODE_HIGH;
		if (conv.channel >= CH_SPARE_A && conv.channel <= CH_SPARE_C) begin
			res_hit = res_hit && !spare_gpio_mode[res_idx[1:0]];
		end
		chk_hit = conv.valid;
		chk_idx = 2'd0;
		unique case (conv.channel)
			CH_SPARE_A:   chk_idx = 2'd0;
			CH_BATT_A:    chk_idx = 2'd1;
			CH_BATT_B:    chk_idx = 2'd2;
			CH_DIODE_LOW: chk_idx = 2'd3;
			default:      chk_hit = 1'b0;
		endcase
		chk_hit = chk_hit && res_hit;
		// Raw codes compared directly; no temperature conversion is done here.
		out_of_limit = conv.data > limit_reg[{chk_idx, 1'b0}]
			|| conv.data < limit_reg[{chk_idx, 1'b1}];
		set_mask = (chk_hit && out_of_limit) ? 4'(1 << chk_idx) : 4'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result and limit registers.

	always_comb begin
		for (int i = 0; i < NUM_RESULTS; i++) begin
			result_next[i] = result_reg[i];
		end
		if (res_hit) begin
			result_next[res_idx] = conv.data;
		end
		for (int i = 0; i < NUM_LIMITS; i++) begin
			limit_next[i] = limit_reg[i];
		end
		if (reg_wr.en && reg_wr.addr >= LIMIT_FIRST_ADDR && reg_wr.addr <= LIMIT_LAST_ADDR) begin
			limit_next[3'(reg_wr.addr - LIMIT_FIRST_ADDR)] = reg_wr.data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_RESULTS; i++) begin
				result_reg[i] <= RESULT_RST;
			end
			for (int i = 0; i < NUM_LIMITS; i++) begin
				limit_reg[i] <= (i % 2 == 0) ? HIGH_LIMIT_RST : LOW_LIMIT_RST;
			end
		end else begin
			result_reg <= result_next;
			limit_reg <= limit_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Alert status, enable and alarm.

	always_comb begin
		status_next = status_reg;
		enable_next = enable_reg;
		if (reg_wr.en && reg_wr.addr == ALERT_STATUS_ENABLE_ADDR) begin
			status_next = status_reg & ~reg_wr.data[ALERT_STATUS_LSB +: 4];
			enable_next = reg_wr.data[ALERT_ENABLE_LSB +: 4];
		end
		// A new alert in the clearing cycle is kept: set beats clear.
		status_next = status_next | set_mask;
		alarm_next = |(status_next & enable_next);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= ALERT_STATUS_RST;
			enable_reg <= ALERT_ENABLE_RST;
			alarm_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			enable_reg <= enable_next;
			alarm_reg <= alarm_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Battery dividers draw current, so each is on only during its own sample.

	always_comb begin
		div_a_next = sample_active && sample_channel == CH_BATT_A;
		div_b_next = sample_active && sample_channel == CH_BATT_B;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_a_reg <= 1'b0;
			div_b_reg <= 1'b0;
		end else begin
			div_a_reg <= div_a_next;
			div_b_reg <= div_b_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read port.

	always_comb begin
		rd_valid_next = reg_rd_en;
		rd_data_next = '0;
		if (reg_rd_en) begin
			if (reg_rd_addr >= AUX_INPUT_A_RESULT_ADDR
				&& reg_rd_addr <= DIODE_HIGH_BIAS_RESULT_ADDR) begin
				rd_data_next = result_reg[3'(reg_rd_addr - AUX_INPUT_A_RESULT_ADDR)];
			end else if (reg_rd_addr >= LIMIT_FIRST_ADDR && reg_rd_addr <= LIMIT_LAST_ADDR) begin
				rd_data_next = limit_reg[3'(reg_rd_addr - LIMIT_FIRST_ADDR)];
			end else if (reg_rd_addr == ALERT_STATUS_ENABLE_ADDR) begin
				rd_data_next = {4'h0, enable_reg, status_reg};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_reg <= '0;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	assign reg_rd_data = rd_data_reg;
	assign reg_rd_valid = rd_valid_reg;
	assign battery_a_div_en = div_a_reg;
	assign battery_b_div_en = div_b_reg;
	assign alarm = alarm_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	diode_low_store_a: assert property (
		conv.valid && conv.channel == CH_DIODE_LOW |=> result_reg[5] == $past(conv.data))
		else $error("low bias diode result not stored");
	diode_high_store_a: assert property (
		conv.valid && conv.channel == CH_DIODE_HIGH |=> result_reg[6] == $past(conv.data))
		else $error("high bias diode result not stored");
	battery_a_store_a: assert property (
		conv.valid && conv.channel == CH_BATT_A |=> result_reg[3] == $past(conv.data))
		else $error("battery a result not stored");
	battery_b_store_a: assert property (
		conv.valid && conv.channel == CH_BATT_B |=> result_reg[4] == $past(conv.data))
		else $error("battery b result not stored");
	spare_b_store_a: assert property (
		conv.valid && conv.channel == CH_SPARE_B && !spare_gpio_mode[1]
		|=> result_reg[1] == $past(conv.data))
		else $error("spare b result not stored");
	spare_gpio_hold_a: assert property (
		conv.valid && conv.channel == CH_SPARE_C && spare_gpio_mode[2] |=> $stable(result_reg[2]))
		else $error("digital mode pin result changed");
	divider_a_gate_a: assert property (
		battery_a_div_en == $past(sample_active && sample_channel == CH_BATT_A))
		else $error("battery a divider wrong");
	divider_b_gate_a: assert property (
		battery_b_div_en |-> $past(sample_active) && $past(sample_channel) == CH_BATT_B)
		else $error("battery b divider on outside sampling");
	diode_alert_set_a: assert property (
		conv.valid && conv.channel == CH_DIODE_LOW && (conv.data > limit_reg[6]
		|| conv.data < limit_reg[7]) |=> status_reg[3])
		else $error("diode alert not set");
	unchecked_no_alert_a: assert property (
		conv.valid && conv.channel == CH_SPARE_B && !reg_wr.en |=> $stable(status_reg))
		else $error("unchecked channel changed status");
	in_limit_quiet_a: assert property (
		conv.valid && conv.channel == CH_BATT_A && !status_reg[1] && !reg_wr.en
		&& conv.data <= limit_reg[2] && conv.data >= limit_reg[3] |=> !status_reg[1])
		else $error("in limit battery result alerted");
	alarm_follow_a: assert property (
		alarm == |(status_reg & enable_reg))
		else $error("alarm does not match status and enable");
	limit_write_a: assert property (
		reg_wr.en && reg_wr.addr == LIMIT_LAST_ADDR |=> limit_reg[7] == $past(reg_wr.data))
		else $error("limit write lost");

	////////////////////////////////////////////////////////////////////////////////
	// Routing checks: every valid code 3 to 9 lands in exactly one result register, except spare codes whose pin is in digital mode; other codes land in none.

	spare_a_store_a: assert property (
		conv.valid && conv.channel == CH_SPARE_A && !spare_gpio_mode[0]
		|=> result_reg[0] == $past(conv.data))
		else $error("spare a result not stored");
	spare_c_store_a: assert property (
		conv.valid && conv.channel == CH_SPARE_C && !spare_gpio_mode[2]
		|=> result_reg[2] == $past(conv.data))
		else $error("spare c result not stored");
	bad_channel_drop_a: assert property (
		conv.valid && (conv.channel < CH_SPARE_A || conv.channel > CH_DIODE_HIGH)
		|=> $stable(result_reg[0]) && $stable(result_reg[1]) && $stable(result_reg[2])
		&& $stable(result_reg[3]) && $stable(result_reg[4]) && $stable(result_reg[5])
		&& $stable(result_reg[6]))
		else $error("invalid channel code changed a result");
	result_write_refused_a: assert property (
		reg_wr.en && reg_wr.addr == AUX_INPUT_A_RESULT_ADDR && !conv.valid
		|=> $stable(result_reg[0]))
		else $error("result register took a host write");
	limit_first_write_a: assert property (
		reg_wr.en && reg_wr.addr == LIMIT_FIRST_ADDR
		|=> limit_reg[0] == $past(reg_wr.data))
		else $error("first limit write lost");
	dividers_apart_a: assert property (
		!(battery_a_div_en && battery_b_div_en))
		else $error("both battery dividers on");

	////////////////////////////////////////////////////////////////////////////////
	// Limit checks: the four checked channels raise their own bit, the others none.

	spare_alert_set_a: assert property (
		conv.valid && conv.channel == CH_SPARE_A && !spare_gpio_mode[0]
		&& (conv.data > limit_reg[0] || conv.data < limit_reg[1]) |=> status_reg[0])
		else $error("spare a alert not set");
	battery_a_alert_a: assert property (
		conv.valid && conv.channel == CH_BATT_A
		&& (conv.data > limit_reg[2] || conv.data < limit_reg[3]) |=> status_reg[1])
		else $error("battery a alert not set");
	battery_b_alert_a: assert property (
		conv.valid && conv.channel == CH_BATT_B
		&& (conv.data > limit_reg[4] || conv.data < limit_reg[5]) |=> status_reg[2])
		else $error("battery b alert not set");
	high_diode_quiet_a: assert property (
		conv.valid && conv.channel == CH_DIODE_HIGH && !reg_wr.en
		|=> $stable(status_reg))
		else $error("high bias diode result changed status");
	status_clear_a: assert property (
		reg_wr.en && reg_wr.addr == ALERT_STATUS_ENABLE_ADDR && !conv.valid
		|=> (status_reg & $past(reg_wr.data[ALERT_STATUS_LSB +: 4])) == 4'h0)
		else $error("written status bit not cleared");
	enable_write_a: assert property (
		reg_wr.en && reg_wr.addr == ALERT_STATUS_ENABLE_ADDR
		|=> enable_reg == $past(reg_wr.data[ALERT_ENABLE_LSB +: 4]))
		else $error("alert enable write lost");
	alarm_quiet_a: assert property (
		enable_reg == 4'h0 && !reg_wr.en |=> !alarm)
		else $error("alarm raised with no enable set");

	////////////////////////////////////////////////////////////////////////////////
	// Read port checks: the answer follows one cycle after the request.

	spare_a_read_a: assert property (
		reg_rd_en && reg_rd_addr == AUX_INPUT_A_RESULT_ADDR
		|=> reg_rd_valid && reg_rd_data == $past(result_reg[0]))
		else $error("spare a result read wrong");
	battery_a_read_a: assert property (
		reg_rd_en && reg_rd_addr == BATTERY_A_RESULT_ADDR
		|=> reg_rd_valid && reg_rd_data == $past(result_reg[3]))
		else $error("battery a result read wrong");
	battery_b_read_a: assert property (
		reg_rd_en && reg_rd_addr == BATTERY_B_RESULT_ADDR
		|=> reg_rd_valid && reg_rd_data == $past(result_reg[4]))
		else $error("battery b result read wrong");
	diode_low_read_a: assert property (
		reg_rd_en && reg_rd_addr == DIODE_LOW_BIAS_RESULT_ADDR
		|=> reg_rd_valid && reg_rd_data == $past(result_reg[5]))
		else $error("low bias diode result read wrong");
	diode_high_read_a: assert property (
		reg_rd_en && reg_rd_addr == DIODE_HIGH_BIAS_RESULT_ADDR
		|=> reg_rd_valid && reg_rd_data == $past(result_reg[6]))
		else $error("high bias diode result read wrong");
	limit_read_a: assert property (
		reg_rd_en && reg_rd_addr == LIMIT_FIRST_ADDR
		|=> reg_rd_valid && reg_rd_data == $past(limit_reg[0]))
		else $error("first limit read wrong");

	alert_raised_c: cover property (conv.valid && conv.channel == CH_DIODE_LOW ##1 alarm);
	battery_sample_c: cover property (battery_a_div_en [*2] ##1 !battery_a_div_en);
	clear_collide_c: cover property (|set_mask && reg_wr.en
		&& reg_wr.addr == ALERT_STATUS_ENABLE_ADDR);
	gpio_drop_c: cover property (conv.valid && conv.channel == CH_SPARE_C
		&& spare_gpio_mode[2]);
	diode_pair_c: cover property (conv.valid && conv.channel == CH_DIODE_LOW
		##2 conv.valid && conv.channel == CH_DIODE_HIGH);

endmodule : alc_aux_limit

/* verification/alc_host_model.sv */
// Purpose: Host processor model that reaches the block's registers.
// Assumes: Requests launch 1 ns after a rising edge and are taken at the next edge.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/1ps

module alc_host_model
	import alc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [DATA_W-1:0] reg_rd_data,
	input  wire logic              reg_rd_valid,
	output alc_wr_t                reg_wr,
	output logic                   reg_rd_en,
	output logic      [ADDR_W-1:0] reg_rd_addr
);
	logic [DATA_W-1:0] rd_word;
	logic              rd_ok;

	initial begin
		reg_wr = '0;
		reg_rd_en = 1'b0;
		reg_rd_addr = '0;
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		#1 reg_wr = '{1'b1, a, d};
		@(posedge clk);
		#1 reg_wr = '{1'b0, ~a, ~d};
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		#1 reg_rd_en = 1'b1;
		reg_rd_addr = a;
		@(posedge clk);
		#1 reg_rd_en = 1'b0;
		reg_rd_addr = ~a;
		// The answer stands for the cycle after the taking edge; take it at the next edge.
		@(posedge clk);
		rd_word = reg_rd_data;
		rd_ok = reg_rd_valid;
		#1;
	endtask : rd

endmodule : alc_host_model

/* verification/alc_aux_limit_tb.sv */
// Purpose: Self-checking bench for the ancillary result and limit block.
// Assumes: Inputs change 1 ns after a rising edge.
// Notes:   Conversions are injected directly; the host model owns the register port.
`timescale 1ns/1ps

module alc_aux_limit_tb
	import alc_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	alc_conv_t         conv = '0;
	logic              sample_active = 1'b0;
	logic [CHAN_W-1:0] sample_channel = '0;
	logic [2:0]        spare_gpio_mode = 3'h0;
	alc_wr_t           reg_wr;
	logic              reg_rd_en;
	logic [ADDR_W-1:0] reg_rd_addr;
	logic [DATA_W-1:0] reg_rd_data;
	logic              reg_rd_valid;
	logic              battery_a_div_en;
	logic              battery_b_div_en;
	logic              alarm;
	int                mismatches = 0;
	int                cmp_count = 0;

	always #2 clk = ~clk;

	alc_aux_limit u_alc_aux_limit (.clk(clk), .rst_n(rst_n), .conv(conv),
		.sample_active(sample_active), .sample_channel(sample_channel),
		.spare_gpio_mode(spare_gpio_mode), .reg_wr(reg_wr), .reg_rd_en(reg_rd_en),
		.reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
		.battery_a_div_en(battery_a_div_en), .battery_b_div_en(battery_b_div_en),
		.alarm(alarm));

	alc_host_model u_alc_host_model (.clk(clk), .reg_rd_data(reg_rd_data),
		.reg_rd_valid(reg_rd_valid), .reg_wr(reg_wr), .reg_rd_en(reg_rd_en),
		.reg_rd_addr(reg_rd_addr));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		u_alc_host_model.rd(a);
		chk("read valid", 12'h001, {11'h0, u_alc_host_model.rd_ok});
		chk($sformatf("reg %h", a), e, u_alc_host_model.rd_word);
	endtask : rchk

	task automatic cv(input logic [3:0] ch, input logic [11:0] d);
		@(posedge clk);
		#1 conv = '{1'b1, ch, d};
		@(posedge clk);
		#1 conv = '{1'b0, ~ch, ~d};
	endtask : cv

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int a = 4; a < 12; a++) rchk(a[4:0], a[0] ? 12'h000 : 12'hfff);
		for (int a = 19; a < 26; a++) rchk(a[4:0], 12'h000);
		rchk(5'h03, 12'h000);
		rchk(5'h1f, 12'h000);
		chk("alarm", 12'h000, {11'h0, alarm});
		$display("test reset done");
	endtask : t_reset

	// Channels 2 and 10 share the converter but must not disturb these results.
	task automatic t_route;
		for (int c = 3; c < 10; c++) cv(c[3:0], {c[3:0], 8'h5a});
		cv(4'h2, 12'heee);
		cv(4'ha, 12'heee);
		u_alc_host_model.wr(5'h13, 12'h000);
		for (int c = 3; c < 10; c++) begin
			rchk(5'h10 + c[4:0], {c[3:0], 8'h5a});
		end
		$display("test route done");
	endtask : t_route

	task automatic t_div;
		logic [4:0] st [4] = '{5'h16, 5'h17, 5'h15, 5'h06};
		foreach (st[i]) begin
			@(posedge clk);
			#1 {sample_active, sample_channel} = st[i];
			@(posedge clk);
			#1 chk("div a", {11'h0, st[i] == 5'h16}, {11'h0, battery_a_div_en});
			chk("div b", {11'h0, st[i] == 5'h17}, {11'h0, battery_b_div_en});
		end
		sample_active = 1'b0;
		$display("test divider done");
	endtask : t_div

	task automatic t_limit;
		logic [3:0] chs [4] = '{4'h3, 4'h6, 4'h7, 4'h8};
		logic [4:0] la;
		for (int i = 0; i < 4; i++) begin
			la = 5'h04 + 5'(2 * i);
			u_alc_host_model.wr(la, 12'h800);
			u_alc_host_model.wr(la + 5'h01, 12'h100);
			rchk(la, 12'h800);
			u_alc_host_model.wr(5'h03, 12'h010 << i);
			cv(chs[i], 12'h800);
			cv(chs[i], 12'h100);
			rchk(5'h03, 12'h010 << i);
			cv(chs[i], 12'h801);
			chk("alarm", 12'h001, {11'h0, alarm});
			rchk(5'h03, 12'h011 << i);
			u_alc_host_model.wr(5'h03, 12'h011 << i);
			chk("alarm", 12'h000, {11'h0, alarm});
			cv(chs[i], 12'h0ff);
			rchk(5'h03, 12'h011 << i);
			u_alc_host_model.wr(5'h03, 12'h001 << i);
			cv(chs[i], 12'hfff);
			chk("alarm", 12'h000, {11'h0, alarm});
			rchk(5'h03, 12'h001 << i);
			u_alc_host_model.wr(5'h03, 12'h001 << i);
		end
		// Diode limits are now narrow, so a checked high-bias channel would trip here.
		// A new diode alert and a clearing write in one cycle: the alert must survive.
		fork
			cv(4'h8, 12'hfff);
			u_alc_host_model.wr(5'h03, 12'h008);
		join
		rchk(5'h03, 12'h008);
		u_alc_host_model.wr(5'h03, 12'h008);
		for (int c = 4; c < 10; c += (c == 5) ? 4 : 1) cv(c[3:0], 12'hfff);
		rchk(5'h03, 12'h000);
		$display("test limit done");
	endtask : t_limit

	task automatic t_gpio;
		for (int c = 3; c < 6; c++) cv(c[3:0], 12'h321);
		spare_gpio_mode = 3'h7;
		for (int c = 3; c < 6; c++) cv(c[3:0], 12'h654);
		for (int c = 3; c < 6; c++) rchk(5'h10 + c[4:0], 12'h321);
		spare_gpio_mode = 3'h0;
		$display("test gpio done");
	endtask : t_gpio

	task automatic report_and_stop;
		$display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(4 * 5000);
		mismatches++;
		report_and_stop();
	end

	initial begin
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		t_reset();
		t_route();
		t_div();
		t_limit();
		t_gpio();
		// A second reset in mid-run must restore every register.
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		t_reset();
		report_and_stop();
	end

endmodule : alc_aux_limit_tb
